// file: core/ttw_consts.vh
// Constants for the tick timer, watchdog and prescalers
`ifndef TTW_CONSTS_VH
`define TTW_CONSTS_VH
`define TTW_WDC_ENABLE_BIT   7
`define TTW_WDC_EXTINT_BIT   6
`define TTW_WDC_PSEN_BIT     3
`define TTW_WDC_WMASK        8'hCF
`define TTW_CTL_SRC_BIT      5
`define TTW_CTL_EDGE_BIT     4
`define TTW_CTL_PSEN_BIT     3
`define TTW_IMR_TICK_BIT     0
`define TTW_IMR_WMASK        8'hC7
`define TTW_PSEL_HI          2
`define TTW_PSEL_LO          0
`define TTW_PSEL_W           3
`define TTW_BYTE_ZERO        8'h00
`define TTW_BYTE_MAX         8'hFF
`define TTW_BYTE_ONE         8'h01
`define TTW_CLK_NS           5
`define TTW_WDT_TIMEOUT_MS   18
`define TTW_WDT_CNT_W        22
// Eighteen milliseconds of 5 ns core cycles
`define TTW_WDT_TIMEOUT_CYC  22'h36EE80
`define TTW_WDT_CNT_ONE      22'h000001
`define TTW_WDT_CNT_ZERO     22'h000000
`endif

// file: core/ttw_prescaler.v
// Eight-bit prescaler with 1:1 bypass and 1:2..1:256 ratio select
`timescale 1ns/1ps
`include "ttw_consts.vh"
module ttw_prescaler (
  // Clock and reset
  input  wire       core_clk,
  input  wire       srst,
  // Control
  input  wire       clear,
  input  wire       tick_in,
  input  wire       enable,
  input  wire [2:0] select,
  // Output
  output wire       tick_out
);
  reg  [7:0] count_q;
  wire [7:0] next_count;
  wire [7:0] tap_mask;
  wire       wrap;

  assign next_count = count_q + `TTW_BYTE_ONE;
  // Ratio 2^(select+1): wrap when low select+1 bits are all ones
  genvar i;
  generate
    for (i = 0; i < 8; i = i + 1) begin : g_mask
      assign tap_mask[i] = (i <= select);
    end
  endgenerate
  assign wrap     = ((count_q & tap_mask) == tap_mask);  // [RULE3]
  assign tick_out = enable ? (tick_in & wrap) : tick_in;  // [RULE2]

  always @(posedge core_clk) begin
    if (srst || clear) begin
      count_q <= `TTW_BYTE_ZERO;
    end else if (enable && tick_in) begin
      count_q <= wrap ? `TTW_BYTE_ZERO : next_count;  // [RULE7]
    end
  end
endmodule // ttw_prescaler

// file: core/ttw_watchdog.v
// Watchdog counter running from the on-chip RC tick
`timescale 1ns/1ps
`include "ttw_consts.vh"
module ttw_watchdog #(
  parameter [`TTW_WDT_CNT_W-1:0] TIMEOUT_CYCLES = `TTW_WDT_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire core_clk,
  input  wire srst,
  // Control
  input  wire clear,
  input  wire enable,
  input  wire step,
  // Result
  output reg  timeout_q
);
  reg  [`TTW_WDT_CNT_W-1:0] count_q;
  wire                      at_end;

  assign at_end = (count_q >= TIMEOUT_CYCLES - `TTW_WDT_CNT_ONE);

  always @(posedge core_clk) begin
    if (srst || clear) begin
      count_q   <= `TTW_WDT_CNT_ZERO;  // [RULE19]
      timeout_q <= 1'b0;
    end else if (enable && step) begin  // [RULE1]
      if (at_end) begin
        count_q   <= `TTW_WDT_CNT_ZERO;
        timeout_q <= 1'b1;  // [RULE16]
      end else begin
        count_q   <= count_q + `TTW_WDT_CNT_ONE;
        timeout_q <= 1'b0;
      end
    end else begin
      timeout_q <= 1'b0;
    end
  end
endmodule // ttw_watchdog

// file: core/ttw_top.v
// Tick timer, watchdog and their prescalers as seen by the core
`timescale 1ns/1ps
`include "ttw_consts.vh"
// Behaviour
// [RULE1] Watchdog counts only while enable bit set
// [RULE2] Watchdog prescaler bypassed when its enable clear
// [RULE3] Ratio is two to the select plus one
// [RULE4] Select bit picks port bit or interrupt
// [RULE5] Software sets pin direction to input first
// [RULE6] Watchdog control bits five, four read zero
// [RULE7] Two separate eight bit prescalers
// [RULE8] Tick counter write clears tick prescaler
// [RULE9] Clear and sleep clear watchdog, prescaler
// [RULE10] Eight bit tick counter, internal or external
// [RULE11] Bank0 bit picks internal tick clock
// [RULE12] External mode counts selected pin edge
// [RULE13] External pin levels last over one clock
// [RULE14] Tick counter halts during sleep
// [RULE15] Watchdog runs from RC tick in sleep
// [RULE16] Enabled watchdog time-out resets device
// [RULE17] Unscaled time-out about eighteen milliseconds
// [RULE18] Tick interrupt needs mask bit and global
// [RULE19] Any reset clears watchdog and prescaler
// [RULE20] Sleep entry clears watchdog, keeps it running
// [RULE21] Wrap sets overflow flag regardless of enable
// [RULE22] Tick prescaler uses same ratio encoding
module ttw_top #(
  parameter [`TTW_WDT_CNT_W-1:0] WDT_TIMEOUT_CYCLES =
    `TTW_WDT_TIMEOUT_CYC
) (
  // Clock and reset
  input  wire       core_clk,
  input  wire       srst,
  // Core register writes
  input  wire       wdc_wr,
  input  wire       imr_wr,
  input  wire       ctl_wr,
  input  wire       tick_wr,
  input  wire       flag_clr,
  input  wire [7:0] wr_data,
  // Instructions
  input  wire       clear_watchdog_instr,
  input  wire       sleep_instr,
  input  wire       global_int_on_instr,
  input  wire       global_int_off_instr,
  input  wire       sleep_active,
  // Clock sources
  input  wire       bank0_clock_sel_bit,
  input  wire       instr_clk_tick,
  input  wire       alt_clk_tick,
  input  wire       rc_osc_tick,
  input  wire       tick_pin,
  // Pins
  input  wire       port6_bit0_pin,
  input  wire       port6_direction,
  // Register views
  output reg  [7:0] watchdog_control_q,
  output reg  [7:0] interrupt_mask_one_q,
  output reg  [7:0] core_control_byte_q,
  output reg  [7:0] tick_counter_q,
  output reg        tick_overflow_flag_q,
  output reg        global_int_q,
  output reg        port6_data_q,
  output reg        ext_int_q,
  output reg        tick_int_req_q,
  output reg        wdt_reset_q
);
  reg  tick_pin_q;
  wire tick_source_clock;
  wire ext_edge;
  wire raw_tick;
  wire scaled_tick;
  wire wdt_step;
  wire wdt_timeout;
  wire wdt_clear;
  wire tick_wrap;
  wire watchdog_enable;
  wire ext_int_select;
  wire wdt_prescale_enable;
  wire tick_int_enable;

  assign watchdog_enable     = watchdog_control_q[`TTW_WDC_ENABLE_BIT];
  assign ext_int_select      = watchdog_control_q[`TTW_WDC_EXTINT_BIT];
  assign wdt_prescale_enable = watchdog_control_q[`TTW_WDC_PSEN_BIT];
  assign tick_int_enable     = interrupt_mask_one_q[`TTW_IMR_TICK_BIT];

  // Internal source choice
  assign tick_source_clock = bank0_clock_sel_bit ?
                             alt_clk_tick : instr_clk_tick;  // [RULE11]
  // Pin treated as synchronous; edge found against last sample
  assign ext_edge = core_control_byte_q[`TTW_CTL_EDGE_BIT] ?
                    (tick_pin_q & ~tick_pin) :
                    (~tick_pin_q & tick_pin);  // [RULE12] [RULE13]
  assign raw_tick = (core_control_byte_q[`TTW_CTL_SRC_BIT] ?
                    ext_edge : tick_source_clock) &
                    ~sleep_active;  // [RULE10] [RULE14]

  ttw_prescaler u_tick_ps (
    .core_clk (core_clk),
    .srst     (srst),
    .clear    (tick_wr),  // [RULE8]
    .tick_in  (raw_tick),
    .enable   (core_control_byte_q[`TTW_CTL_PSEN_BIT]),
    .select   (core_control_byte_q[`TTW_PSEL_HI:`TTW_PSEL_LO]),  // [RULE22]
    .tick_out (scaled_tick)
  );

  // Sleep entry and clear instruction restart the watchdog
  assign wdt_clear = clear_watchdog_instr | sleep_instr;  // [RULE9] [RULE20]

  ttw_prescaler u_wdt_ps (
    .core_clk (core_clk),
    .srst     (srst),
    .clear    (wdt_clear),
    .tick_in  (rc_osc_tick),  // [RULE15]
    .enable   (wdt_prescale_enable),  // [RULE2]
    .select   (watchdog_control_q[`TTW_PSEL_HI:`TTW_PSEL_LO]),  // [RULE3]
    .tick_out (wdt_step)
  );

  // Step count is per RC tick; 18 ms maps via core clock rate
  ttw_watchdog #(
    .TIMEOUT_CYCLES (WDT_TIMEOUT_CYCLES)  // [RULE17]
  ) u_wdt (
    .core_clk  (core_clk),
    .srst      (srst),
    .clear     (wdt_clear),
    .enable    (watchdog_enable),  // [RULE1]
    .step      (wdt_step),
    .timeout_q (wdt_timeout)
  );

  assign tick_wrap = scaled_tick && (tick_counter_q == `TTW_BYTE_MAX);

  always @(posedge core_clk) begin
    if (srst) begin
      watchdog_control_q   <= `TTW_BYTE_ZERO;
      interrupt_mask_one_q <= `TTW_BYTE_ZERO;
      core_control_byte_q  <= `TTW_BYTE_ZERO;
      tick_counter_q       <= `TTW_BYTE_ZERO;
      tick_overflow_flag_q <= 1'b0;
      global_int_q         <= 1'b0;
      port6_data_q         <= 1'b0;
      ext_int_q            <= 1'b0;
      tick_int_req_q       <= 1'b0;
      wdt_reset_q          <= 1'b0;
      tick_pin_q           <= 1'b0;
    end else begin
      tick_pin_q <= tick_pin;
      if (wdc_wr) begin
        watchdog_control_q <= wr_data & `TTW_WDC_WMASK;  // [RULE6]
      end
      if (imr_wr) begin
        interrupt_mask_one_q <= wr_data & `TTW_IMR_WMASK;
      end
      if (ctl_wr) begin
        core_control_byte_q <= wr_data;
      end
      // Software write wins over a coincident count
      if (tick_wr) begin
        tick_counter_q <= wr_data;
      end else if (scaled_tick) begin
        tick_counter_q <= tick_counter_q + `TTW_BYTE_ONE;  // [RULE10]
      end
      // Set wins over clear
      if (tick_wrap) begin
        tick_overflow_flag_q <= 1'b1;  // [RULE21]
      end else if (flag_clr) begin
        tick_overflow_flag_q <= 1'b0;
      end
      if (global_int_on_instr) begin
        global_int_q <= 1'b1;
      end else if (global_int_off_instr) begin
        global_int_q <= 1'b0;
      end
      tick_int_req_q <= tick_overflow_flag_q & tick_int_enable &
                        global_int_q;  // [RULE18]
      // Pin level stays readable in both functions
      port6_data_q <= port6_bit0_pin;  // [RULE4]
      // Direction input needed; masked otherwise
      ext_int_q <= ext_int_select & port6_direction &
                   ~port6_bit0_pin;  // [RULE4] [RULE5]
      wdt_reset_q <= wdt_timeout;  // [RULE16]
    end
  end
endmodule // ttw_top

// file: bench/ttw_top_asserts.sv
// Checker for the tick timer and watchdog top
`timescale 1ns/1ps
module ttw_top_chk (
  // Clock and reset
  input wire       core_clk,
  input wire       srst,
  // Inputs
  input wire       wdc_wr,
  input wire       tick_wr,
  input wire [7:0] wr_data,
  input wire       sleep_active,
  input wire       port6_bit0_pin,
  input wire       port6_direction,
  // Outputs
  input wire [7:0] watchdog_control_q,
  input wire [7:0] interrupt_mask_one_q,
  input wire [7:0] tick_counter_q,
  input wire       tick_overflow_flag_q,
  input wire       global_int_q,
  input wire       ext_int_q,
  input wire       tick_int_req_q,
  input wire       wdt_reset_q
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  // Three idle cycles drain any step still in flight
  sequence wdt_off_s;
    !watchdog_control_q[7] [*3];
  endsequence
  // A load of zero is not a wrap
  sequence wrap_s;
    tick_counter_q == 8'hFF && !tick_wr ##1 tick_counter_q == 8'h00;
  endsequence
  wdc_bits_a: assert property (watchdog_control_q[5:4] == 2'h0)
    else $error("watchdog control bits 5 and 4 not zero");
  wdc_write_a: assert property (wdc_wr |=>
    watchdog_control_q == ($past(wr_data) & 8'hCF)) else $error("wdc write");
  tick_load_a: assert property (tick_wr |=>
    tick_counter_q == $past(wr_data)) else $error("tick load");
  sleep_hold_a: assert property (sleep_active && !tick_wr |=>
    tick_counter_q == $past(tick_counter_q)) else $error("sleep count");
  int_req_a: assert property (1'h1 |=> tick_int_req_q ==
    $past(tick_overflow_flag_q & interrupt_mask_one_q[0] & global_int_q))
    else $error("tick int request");
  wdt_off_a: assert property (wdt_off_s |=> !wdt_reset_q)
    else $error("reset while watchdog off");
  ext_int_a: assert property (1'h1 |=> ext_int_q ==
    $past(watchdog_control_q[6] & port6_direction & ~port6_bit0_pin))
    else $error("ext int path");
  wrap_flag_a: assert property (wrap_s |-> tick_overflow_flag_q)
    else $error("wrap without flag");
endmodule // ttw_top_chk
bind ttw_top ttw_top_chk u_chk (.*);

// file: bench/tick_timer_watchdog_prescaler_bench.sv
// Self-checking bench for the tick timer and watchdog top
`timescale 1ns/1ps
module tick_timer_watchdog_prescaler_bench;
  // Stimulus
  reg        core_clk = 1'h0, srst = 1'h1, flag_clr = 1'h0;
  reg        wdc_wr = 1'h0, imr_wr = 1'h0, ctl_wr = 1'h0, tick_wr = 1'h0;
  reg  [7:0] wr_data = 8'h00;
  reg        clear_watchdog_instr = 1'h0, sleep_instr = 1'h0;
  reg        global_int_on_instr = 1'h0, global_int_off_instr = 1'h0;
  reg        sleep_active = 1'h0, bank0_clock_sel_bit = 1'h0;
  reg        instr_clk_tick = 1'h0, alt_clk_tick = 1'h0;
  reg        rc_osc_tick = 1'h1, tick_pin = 1'h0;
  reg        port6_bit0_pin = 1'h0, port6_direction = 1'h1;
  // Observed
  wire [7:0] watchdog_control_q, interrupt_mask_one_q;
  wire [7:0] core_control_byte_q, tick_counter_q;
  wire       tick_overflow_flag_q, global_int_q, port6_data_q;
  wire       ext_int_q, tick_int_req_q, wdt_reset_q;
  integer    n_errors = 0, total_checks = 0, n, s;
  // Short time-out keeps the watchdog runs brief
  ttw_top #(.WDT_TIMEOUT_CYCLES(22'h000008)) u_dut (.*);
  always #2.5 core_clk = ~core_clk;
  task step;
    @(posedge core_clk);
    #1;
  endtask
  task conclude;
    if (n_errors == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task chk(input string what, input [7:0] exp, input [7:0] got);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("FAIL %0s exp %h got %h", what, exp, got);
    end
  endtask
  // Strobe order: watchdog, mask, control, counter
  task wr(input [3:0] k, input [7:0] d);
    {wdc_wr, imr_wr, ctl_wr, tick_wr} = k;
    wr_data = d;
    step;
    {wdc_wr, imr_wr, ctl_wr, tick_wr} = 4'h0;
    step;
  endtask
  task wait_rst(output integer c);
    c = 0;
    while (wdt_reset_q !== 1'h1 && c < 300) begin
      step;
      c = c + 1;
    end
    if (c >= 300) begin
      n_errors = n_errors + 1;
      $display("FAIL wdt reset exp 1 got 0");
      conclude;
    end
  endtask
  task t_wdt;
    wr(4'h8, 8'h80);
    wait_rst(n);
    chk("wdt 1:1", 8'h01, {7'h00, n >= 5 && n <= 10});
    repeat (4) step;
    clear_watchdog_instr = 1'h1;
    step;
    clear_watchdog_instr = 1'h0;
    wait_rst(n);
    chk("wdt clear", 8'h01, {7'h00, n >= 6 && n <= 10});
    wr(4'h8, 8'h88);
    sleep_instr = 1'h1;
    step;
    sleep_instr = 1'h0;
    wait_rst(n);
    chk("wdt 1:2", 8'h01, {7'h00, n >= 14 && n <= 20});
    wr(4'h8, 8'h00);
  endtask
  // Mid-run reset must restart a half-run watchdog from zero
  task t_rst;
    wr(4'h8, 8'h80);
    repeat (4) step;
    srst = 1'h1;
    repeat (3) step;
    srst = 1'h0;
    chk("rst wdc", 8'h00, watchdog_control_q);
    wr(4'h8, 8'h80);
    wait_rst(n);
    chk("rst wdt", 8'h01, {7'h00, n >= 6 && n <= 10});
    wr(4'h8, 8'h00);
  endtask
  task t_regs;
    wr(4'h8, 8'hFF);
    chk("wdc", 8'hCF, watchdog_control_q);
    chk("ext int", 8'h01, {7'h00, ext_int_q});
    port6_bit0_pin = 1'h1;
    step;
    chk("pin read", 8'h01, {7'h00, port6_data_q});
    chk("ext idle", 8'h00, {7'h00, ext_int_q});
    port6_bit0_pin = 1'h0;
    wr(4'h4, 8'hFF);
    chk("imr", 8'hC7, interrupt_mask_one_q);
    wr(4'h2, 8'hFF);
    chk("ctl", 8'hFF, core_control_byte_q);
    wr(4'h8, 8'h00);
    chk("ext mask", 8'h00, {7'h00, ext_int_q});
    wr(4'h2, 8'h00);
  endtask
  task t_tick;
    wr(4'h4, 8'h01);
    global_int_on_instr = 1'h1;
    step;
    global_int_on_instr = 1'h0;
    wr(4'h1, 8'hFF);
    instr_clk_tick = 1'h1;
    step;
    instr_clk_tick = 1'h0;
    chk("wrap", 8'h00, tick_counter_q);
    chk("flag", 8'h01, {7'h00, tick_overflow_flag_q});
    step;
    chk("tick int", 8'h01, {7'h00, tick_int_req_q});
    global_int_off_instr = 1'h1;
    step;
    global_int_off_instr = 1'h0;
    step;
    chk("int off", 8'h00, {7'h00, tick_int_req_q});
    {bank0_clock_sel_bit, flag_clr, instr_clk_tick} = 3'h7;
    step;
    {flag_clr, instr_clk_tick, alt_clk_tick} = 3'h1;
    step;
    {bank0_clock_sel_bit, alt_clk_tick} = 2'h0;
    step;
    chk("alt src", 8'h01, tick_counter_q);
    chk("flag clr", 8'h00, {7'h00, tick_overflow_flag_q});
  endtask
  task t_presc;
    for (s = 0; s < 8; s = s + 1) begin
      wr(4'h2, 8'h08 | s[7:0]);
      wr(4'h1, 8'h00);
      instr_clk_tick = 1'h1;
      repeat (256) step;
      instr_clk_tick = 1'h0;
      step;
      chk("ratio", 8'h80 >> s, tick_counter_q);
    end
    wr(4'h2, 8'h08);
    instr_clk_tick = 1'h1;
    step;
    instr_clk_tick = 1'h0;
    wr(4'h1, 8'h10);
    instr_clk_tick = 1'h1;
    step;
    instr_clk_tick = 1'h0;
    step;
    chk("psc clear", 8'h10, tick_counter_q);
  endtask
  // Sleep pass must leave the count untouched
  task t_ext;
    for (s = 0; s < 3; s = s + 1) begin
      wr(4'h2, s == 1 ? 8'h30 : 8'h20);
      wr(4'h1, 8'h00);
      sleep_active = (s == 2);
      repeat (4) begin
        tick_pin = ~tick_pin;
        repeat (2) step;
      end
      step;
      chk("ext edge", s == 2 ? 8'h00 : 8'h02, tick_counter_q);
    end
    sleep_active = 1'h0;
  endtask
  initial begin
    repeat (3) @(posedge core_clk);
    #1;
    srst = 1'h0;
    chk("reset wdc", 8'h00, watchdog_control_q);
    t_wdt;
    t_rst;
    t_regs;
    t_tick;
    t_presc;
    t_ext;
    conclude;
  end
endmodule // tick_timer_watchdog_prescaler_bench
